// file: iep_core_model.sv
// Core model: accepts a presented request and leaves routines on command.
// Assumes the bench raises i_take or i_leave for one cycle at a time.
`timescale 1ns/1ps
module iep_core_model
    import iep_pkg::*;
(
    input wire logic i_clk, // Core clock.
    input wire logic i_rst_n, // Reset, active low.
    input wire iep_req_s i_req, // Request from the controller.
    input wire logic i_take, // Accept the request now shown.
    input wire logic i_leave, // Leave the innermost routine.
    output logic o_ack, // Accept pulse.
    output logic o_reti // Return pulse.
);
    // An accept comes a cycle late, as after finishing an instruction,
    // so a request that vanished meanwhile is answered for nothing.
    always_ff @(posedge i_clk) begin
        o_ack <= i_rst_n && i_take && i_req.valid;
        o_reti <= i_rst_n && i_leave;
    end
endmodule : iep_core_model

// file: iep_ctrl.sv
// Interrupt enable, priority and arbitration for the core.
// Assumes the core drives sfr requests on i_clk and returns acknowledge
// and return-from-service pulses; source requests are same-clock logic.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - External interrupt zero passes only while enable bit 0 is set.
// - Priority bit 7 makes energy interrupt high when set.
// - Priority bit 6 makes temperature interrupt high when set.
// - Priority bits 5, 3, 1 set timer two, one, zero level.
// - Priority bit 4 makes UART interrupt high when set.
// - Priority bits 2 and 0 set external one and zero level.
// - Secondary bit 6 makes the clock interrupt high when set.
// - Secondary bit 4 makes serial interface interrupt high when set.
// - Energy interrupt passes only while secondary bit 3 is set.
// - Clock interval interrupt passes only while secondary bit 2 set.
// - Supply monitor interrupt passes only while secondary bit 1 set.
// - Serial interface interrupt passes only while secondary bit 0 set.
// - Global enable bit 7 of main enable gates every source.
// - Supply monitor sits alone above both levels and pre-empts all.
// - High pre-empts low; simultaneous high beats low.
// - Same level never pre-empts; ties resolved by fixed polling order.
module iep_ctrl
    import iep_pkg::*;
(
    input wire logic i_clk, // Core clock, 10 MHz.
    input wire logic i_rst_n, // Synchronous reset, active low.
    input wire iep_bus_s i_bus, // Register access from the core.
    output logic [7:0] o_rdata, // Read data, registered.
    input wire logic [IEP_NSRC-1:0] i_src, // Source requests, levels.
    input wire logic i_supply, // Supply monitor request, level.
    input wire logic i_ack, // Core takes the presented request.
    input wire logic i_reti, // Core leaves the innermost routine.
    output iep_req_s o_req, // Request to the core.
    output logic [2:0] o_active // In-service levels: supply, high, low.
);

    ////////////////////////////////////////////////////////////////////////
    // State of the block in one struct.
    typedef struct packed {
        logic [7:0] enable;
        logic [7:0] prio;
        logic [7:0] sec;
        logic [7:0] rdata;
        logic [2:0] active;
    } iep_state_s;

    iep_state_s st_q;
    iep_state_s st_d;

    logic [IEP_NSRC-1:0] en_vec;
    logic [IEP_NSRC-1:0] hi_vec;
    logic [IEP_NSRC-1:0] pend_hi;
    logic [IEP_NSRC-1:0] pend_lo;
    logic any_hi;
    logic any_lo;
    logic [3:0] idx_hi;
    logic [3:0] idx_lo;
    logic supply_ok;
    iep_req_s req;

    ////////////////////////////////////////////////////////////////////////
    // Register selector shared by the write and the read paths.
    typedef enum logic [1:0] {
        IEP_SEL_NONE = 2'b00,
        IEP_SEL_ENABLE = 2'b01,
        IEP_SEL_PRIO = 2'b10,
        IEP_SEL_SEC = 2'b11
    } iep_sel_e;

    // One decoder for both paths, so a read never sees a different map.
    function automatic iep_sel_e decode_addr(input logic [7:0] addr);
        iep_sel_e sel;
        case (addr)
            IEP_ADDR_ENABLE: sel = IEP_SEL_ENABLE;
            IEP_ADDR_PRIO: sel = IEP_SEL_PRIO;
            IEP_ADDR_SEC: sel = IEP_SEL_SEC;
            default: sel = IEP_SEL_NONE;
        endcase
        return sel;
    endfunction : decode_addr

    // Both levels gate their pending bits the same way.
    function automatic logic [IEP_NSRC-1:0] gate_pend(
        input logic [IEP_NSRC-1:0] src,
        input logic [IEP_NSRC-1:0] en,
        input logic [IEP_NSRC-1:0] lvl,
        input logic glob
    );
        return src & en & lvl & {IEP_NSRC{glob}};
    endfunction : gate_pend

    // Return leaves the innermost routine, which is the highest level set.
    // A return with nothing in service changes nothing.
    function automatic logic [2:0] drop_innermost(input logic [2:0] act);
        logic [2:0] res;
        res = act;
        if (act[2]) begin
            res[2] = 1'b0;
        end else if (act[1]) begin
            res[1] = 1'b0;
        end else begin
            res[0] = 1'b0;
        end
        return res;
    endfunction : drop_innermost

    ////////////////////////////////////////////////////////////////////////
    // Per-source enables in polling order; bit 0 of main enable is ext0.
    always_comb begin
        en_vec = '0;
        en_vec[6:0] = st_q.enable[6:0];
        en_vec[7] = st_q.sec[IEP_BIT_ENERGY_EN];
        en_vec[8] = st_q.sec[IEP_BIT_RTC_EN];
        en_vec[9] = st_q.sec[IEP_BIT_SIF_EN];
    end

    // Per-source levels; priority bits share positions with the sources.
    always_comb begin
        hi_vec = '0;
        hi_vec[7:0] = st_q.prio;
        hi_vec[8] = st_q.sec[IEP_BIT_RTC_PRIO];
        hi_vec[9] = st_q.sec[IEP_BIT_SIF_PRIO];
    end

    // Nothing reaches the core without the global enable.
    always_comb begin
        pend_hi = gate_pend(i_src, en_vec, hi_vec,
            st_q.enable[IEP_BIT_GLOBAL]);
        pend_lo = gate_pend(i_src, en_vec, ~hi_vec,
            st_q.enable[IEP_BIT_GLOBAL]);
        supply_ok = i_supply & st_q.sec[IEP_BIT_SUPPLY_EN]
            & st_q.enable[IEP_BIT_GLOBAL];
    end

    ////////////////////////////////////////////////////////////////////////
    // One picker per level keeps the polling order identical for both.
    iep_pick u_pick_hi (
        .i_pend(pend_hi),
        .o_any(any_hi),
        .o_idx(idx_hi)
    );

    iep_pick u_pick_lo (
        .i_pend(pend_lo),
        .o_any(any_lo),
        .o_idx(idx_lo)
    );

    // A request only goes out if its level is above everything in service.
    always_comb begin
        req.valid = 1'b0;
        req.vec = 4'h0;
        req.lvl = IEP_LVL_NONE;
        if (supply_ok && !st_q.active[2]) begin
            req.valid = 1'b1;
            req.vec = IEP_VEC_SUPPLY;
            req.lvl = IEP_LVL_SUPPLY;
        end else if (any_hi && st_q.active[2:1] == 2'b00) begin
            req.valid = 1'b1;
            req.vec = idx_hi;
            req.lvl = IEP_LVL_HIGH;
        end else if (any_lo && st_q.active == 3'b000) begin
            req.valid = 1'b1;
            req.vec = idx_lo;
            req.lvl = IEP_LVL_LOW;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state: register writes, read data and in-service tracking.
    always_comb begin
        st_d = st_q;
        if (i_bus.wr) begin
            case (decode_addr(i_bus.addr))
                IEP_SEL_ENABLE: begin
                    st_d.enable = i_bus.wdata;
                end
                IEP_SEL_PRIO: begin
                    st_d.prio = i_bus.wdata;
                end
                IEP_SEL_SEC: begin
                    st_d.sec = (i_bus.wdata & IEP_SEC_WMASK)
                        | (st_q.sec & ~IEP_SEC_WMASK);
                end
                default: begin
                end
            endcase
        end
        if (i_bus.rd) begin
            case (decode_addr(i_bus.addr))
                IEP_SEL_ENABLE: st_d.rdata = st_q.enable;
                IEP_SEL_PRIO: st_d.rdata = st_q.prio;
                IEP_SEL_SEC: st_d.rdata = st_q.sec;
                default: st_d.rdata = 8'h00;
            endcase
        end
        // Return clears the innermost level first; a new entry wins.
        if (i_reti) begin
            st_d.active = drop_innermost(st_q.active);
        end
        if (i_ack && req.valid) begin
            case (req.lvl)
                IEP_LVL_SUPPLY: st_d.active[2] = 1'b1;
                IEP_LVL_HIGH: st_d.active[1] = 1'b1;
                IEP_LVL_LOW: st_d.active[0] = 1'b1;
                default: st_d.active = st_d.active;
            endcase
        end
    end

    // Single register stage for all state.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q.enable <= IEP_RST_ENABLE;
            st_q.prio <= IEP_RST_PRIO;
            st_q.sec <= IEP_RST_SEC;
            st_q.rdata <= 8'h00;
            st_q.active <= 3'b000;
        end else begin
            st_q <= st_d;
        end
    end

    // Request is combinational handshake; data outputs are registered.
    assign o_req = req;
    assign o_rdata = st_q.rdata;
    assign o_active = st_q.active;

endmodule : iep_ctrl

// file: iep_ctrl_sva.sv
// Checker for the interrupt enable and priority controller.
// Assumes it is bound to iep_ctrl and sees that module's ports only.
`timescale 1ns/1ps
module iep_ctrl_sva
    import iep_pkg::*;
(
    input wire logic i_clk, // Core clock.
    input wire logic i_rst_n, // Reset, active low.
    input wire iep_bus_s i_bus, // Register access.
    input wire logic [7:0] o_rdata, // Read data.
    input wire logic [IEP_NSRC-1:0] i_src, // Source levels.
    input wire logic i_supply, // Supply request.
    input wire logic i_ack, // Core accept pulse.
    input wire logic i_reti, // Core return pulse.
    input wire iep_req_s o_req, // Presented request.
    input wire logic [2:0] o_active // In-service levels.
);
////////////////////////////////////////////////////////////////////////////
    // Every check runs on the core clock and pauses during reset.
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_reset_quiet: assert property ($rose(i_rst_n) |->
        o_active == 3'h0 && !o_req.valid) else $error("busy after reset");
    chk_supply_vec: assert property (o_req.lvl == IEP_LVL_SUPPLY
        && o_req.valid |-> i_supply && o_req.vec == IEP_VEC_SUPPLY)
        else $error("supply level without supply request");
    chk_ack_supply: assert property (i_ack && o_req.valid &&
        o_req.lvl == IEP_LVL_SUPPLY |=> o_active[2])
        else $error("supply service not entered");
    chk_reti_clr: assert property (i_reti && !i_ack &&
        o_active[2] |=> !o_active[2]) else $error("return kept supply");
    chk_ack_high: assert property (i_ack && o_req.valid &&
        o_req.lvl == IEP_LVL_HIGH |=> o_active[1])
        else $error("high service not entered");
    chk_vec_src: assert property (o_req.valid &&
        o_req.lvl != IEP_LVL_SUPPLY |-> i_src[o_req.vec])
        else $error("vector of an idle source");
    chk_high_block: assert property (o_active[1] && o_req.valid |->
        o_req.lvl == IEP_LVL_SUPPLY) else $error("preempted high level");
    chk_low_block: assert property (o_active[0] && o_req.valid |->
        o_req.lvl != IEP_LVL_LOW) else $error("preempted low level");
    chk_low_hold: assert property (o_active[0] && !i_reti |=>
        o_active[0]) else $error("low service lost");
    chk_rsv_read: assert property (i_bus.rd &&
        i_bus.addr == IEP_ADDR_SEC |=> o_rdata[7] && o_rdata[5])
        else $error("reserved bits read low");
    // Main scenarios: full nesting, a high request, return from supply, return meeting accept.
    cover property (o_active == 3'h7);
    cover property (o_req.valid && o_req.lvl == IEP_LVL_HIGH);
    cover property (i_reti && o_active[2]);
    cover property (i_reti && i_ack && o_req.valid);
endmodule : iep_ctrl_sva

bind iep_ctrl iep_ctrl_sva u_sva (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_bus(i_bus), .o_rdata(o_rdata), .i_src(i_src), .i_supply(i_supply),
    .i_ack(i_ack), .i_reti(i_reti), .o_req(o_req), .o_active(o_active));

// file: iep_pick.sv
// Fixed-order picker: lowest-index pending source wins.
// Assumes pending bits already gated by enables and level.
`timescale 1ns/1ps
module iep_pick
    import iep_pkg::*;
(
    input wire logic [IEP_NSRC-1:0] i_pend, // Pending sources.
    output logic o_any, // Any source pending.
    output logic [3:0] o_idx // Index of the winner.
);
    // Scan from the top so the lowest index is left standing.
    always_comb begin
        o_any = 1'b0;
        o_idx = 4'h0;
        for (int k = IEP_NSRC - 1; k >= 0; k--) begin
            if (i_pend[k]) begin
                o_any = 1'b1;
                o_idx = 4'(k);
            end
        end
    end
endmodule : iep_pick

// file: iep_pkg.sv
// Package for the interrupt enable and priority block.
// Assumes an 8-bit special-function register port from the core.
package iep_pkg;
    // Register addresses on the special-function bus.
    localparam logic [7:0] IEP_ADDR_ENABLE = 8'hA8;
    localparam logic [7:0] IEP_ADDR_PRIO = 8'hB8;
    localparam logic [7:0] IEP_ADDR_SEC = 8'hA9;
    // Reset values.
    localparam logic [7:0] IEP_RST_ENABLE = 8'h00;
    localparam logic [7:0] IEP_RST_PRIO = 8'h00;
    localparam logic [7:0] IEP_RST_SEC = 8'hA0;
    // Writable bits of the secondary register; bits 7 and 5 are reserved.
    localparam logic [7:0] IEP_SEC_WMASK = 8'h5F;
    // Main enable register fields.
    localparam int IEP_BIT_GLOBAL = 7;
    // Secondary register fields.
    localparam int IEP_BIT_RTC_PRIO = 6;
    localparam int IEP_BIT_SIF_PRIO = 4;
    localparam int IEP_BIT_ENERGY_EN = 3;
    localparam int IEP_BIT_RTC_EN = 2;
    localparam int IEP_BIT_SUPPLY_EN = 1;
    localparam int IEP_BIT_SIF_EN = 0;
    // Number of configurable sources, in polling order (0 polled first).
    // 0 ext0, 1 timer0, 2 ext1, 3 timer1, 4 uart, 5 timer2, 6 temp,
    // 7 energy, 8 rtc, 9 serial interface.
    localparam int IEP_NSRC = 10;
    localparam logic [3:0] IEP_VEC_SUPPLY = 4'hA;

    // Service level codes.
    typedef enum logic [1:0] {
        IEP_LVL_LOW = 2'b00,
        IEP_LVL_HIGH = 2'b01,
        IEP_LVL_SUPPLY = 2'b10,
        IEP_LVL_NONE = 2'b11
    } iep_level_e;

    // Register bus request from the core.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iep_bus_s;

    // Request presented to the core.
    typedef struct packed {
        logic valid;
        logic [3:0] vec;
        iep_level_e lvl;
    } iep_req_s;
endpackage : iep_pkg

// file: tb_iep_ctrl.sv
// Testbench for the interrupt enable and priority controller.
// Assumes the controller, its checker and the core model compile first.
`timescale 1ns/1ps
module tb_iep_ctrl import iep_pkg::*;;
    typedef struct packed {
        logic [23:0] regs; // Enable, priority, secondary.
        logic [9:0] src;
        logic sup;
        logic [7:0] exp; // Zero, valid, vector, level.
    } iep_row_s;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    iep_bus_s bus = '0;
    logic [9:0] src = 10'h000;
    logic sup = 1'b0, take = 1'b0, leave = 1'b0, ack, reti;
    logic [7:0] rdata;
    iep_req_s req;
    logic [2:0] act;
    int failures = 0, n_compared = 0, cycles = 0;
    iep_row_s rows[19] = '{
        '{24'h810000, 10'h001, 1'b0, 8'h40},
        '{24'h800000, 10'h001, 1'b0, 8'h00},
        '{24'h010000, 10'h001, 1'b0, 8'h00},
        '{24'h810100, 10'h001, 1'b0, 8'h41},
        '{24'hFF800F, 10'h3FF, 1'b0, 8'h5D},
        '{24'hFF400F, 10'h3FF, 1'b0, 8'h59},
        '{24'hFF200F, 10'h3FF, 1'b0, 8'h55},
        '{24'hFF080F, 10'h3FF, 1'b0, 8'h4D},
        '{24'hFF020F, 10'h3FF, 1'b0, 8'h45},
        '{24'hFF100F, 10'h3FF, 1'b0, 8'h51},
        '{24'hFF040F, 10'h3FF, 1'b0, 8'h49},
        '{24'hFF004F, 10'h3FF, 1'b0, 8'h61},
        '{24'hFF001F, 10'h3FF, 1'b0, 8'h65},
        '{24'hFF000F, 10'h3FF, 1'b0, 8'h40},
        '{24'h800000, 10'h380, 1'b1, 8'h00},
        '{24'h800008, 10'h380, 1'b0, 8'h5C},
        '{24'h800004, 10'h300, 1'b0, 8'h60},
        '{24'h800001, 10'h200, 1'b0, 8'h64},
        '{24'h800002, 10'h3FF, 1'b1, 8'h6A}};
    iep_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus),
        .o_rdata(rdata), .i_src(src), .i_supply(sup), .i_ack(ack),
        .i_reti(reti), .o_req(req), .o_active(act));
    iep_core_model core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_req(req),
        .i_take(take), .i_leave(leave), .o_ack(ack), .o_reti(reti));
////////////////////////////////////////////////////////////////////////////
    task tally_and_finish;
        if (failures == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : tally_and_finish
    task check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Bus strobes last one cycle and drop for one before the next access.
    task wr(input logic [7:0] a, input logic [7:0] d);
        bus = '{1'b1, 1'b0, a, d};
        @(posedge i_clk);
        #1 bus = '0;
        @(posedge i_clk);
        #1;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        bus = '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_clk);
        #1 bus = '0;
        @(posedge i_clk);
        #1 check(rdata, e);
    endtask : rd
    task step(input logic t, input logic l);
        take = t;
        leave = l;
        @(posedge i_clk);
        #1 take = 1'b0;
        leave = 1'b0;
        @(posedge i_clk);
        #1;
    endtask : step
    // Vector and level fields hide behind valid, as the core sees them.
    function logic [7:0] seen();
        return req.valid ? {1'b0, req} : 8'h00;
    endfunction : seen
////////////////////////////////////////////////////////////////////////////
    // Free-running 10 MHz core clock.
    initial forever #50 i_clk = ~i_clk;
    // A hang counts as a failure and still reaches the verdict.
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (12) @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        foreach (rows[i]) begin
            wr(IEP_ADDR_ENABLE, rows[i].regs[23:16]);
            wr(IEP_ADDR_PRIO, rows[i].regs[15:8]);
            wr(IEP_ADDR_SEC, rows[i].regs[7:0]);
            src = rows[i].src;
            sup = rows[i].sup;
            @(posedge i_clk);
            #1 check(seen(), rows[i].exp);
        end
        // Nesting: low, then high over low, then supply over both.
        wr(IEP_ADDR_ENABLE, 8'h87);
        wr(IEP_ADDR_PRIO, 8'h02);
        src = 10'h005;
        sup = 1'b0;
        @(posedge i_clk);
        #1 check(seen(), 8'h40);
        step(1'b1, 1'b0);
        check(seen(), 8'h00);
        src = 10'h007;
        @(posedge i_clk);
        #1 check(seen(), 8'h45);
        step(1'b1, 1'b0);
        sup = 1'b1;
        @(posedge i_clk);
        #1 check(seen(), 8'h6A);
        step(1'b1, 1'b0);
        check({5'h00, act}, 8'h07);
        sup = 1'b0;
        step(1'b0, 1'b1);
        check({5'h00, act}, 8'h03);
        // Second reset in mid-run, then reset values and reserved bits.
        i_rst_n = 1'b0;
        @(posedge i_clk);
        #1 i_rst_n = 1'b1;
        check({5'h00, act}, 8'h00);
        rd(IEP_ADDR_ENABLE, 8'h00);
        rd(IEP_ADDR_PRIO, 8'h00);
        rd(IEP_ADDR_SEC, 8'hA0);
        wr(IEP_ADDR_SEC, 8'h00);
        rd(IEP_ADDR_SEC, 8'hA0);
        wr(IEP_ADDR_SEC, 8'hFF);
        rd(IEP_ADDR_SEC, 8'hFF);
        rd(8'hC0, 8'h00);
        // Nonzero read paths, an unmapped write, then return with accept.
        wr(IEP_ADDR_ENABLE, 8'h3C);
        rd(IEP_ADDR_ENABLE, 8'h3C);
        wr(IEP_ADDR_PRIO, 8'hC3);
        wr(8'hC0, 8'hFF);
        rd(IEP_ADDR_PRIO, 8'hC3);
        wr(IEP_ADDR_ENABLE, 8'h83);
        wr(IEP_ADDR_PRIO, 8'h02);
        src = 10'h001;
        step(1'b1, 1'b0);
        check({5'h00, act}, 8'h01);
        src = 10'h003;
        step(1'b1, 1'b1);
        check({5'h00, act}, 8'h02);
        check(seen(), 8'h00);
        tally_and_finish();
    end
endmodule : tb_iep_ctrl
